/* common/upa_defs.vh */
// register map and field constants for the utopia input phy address bank
// included by the bank module; definitions only
`ifndef UPA_DEFS_VH
`define UPA_DEFS_VH
// register indices as printed, byte address is four times the index
`define UPA_IDX_LINK_ADDR0  12'h000
`define UPA_IDX_GROUP_ADDR0 12'h008
`define UPA_IDX_LINK_EN     12'h00C
`define UPA_IDX_GROUP_EN    12'h00D
`define UPA_ADDR_MSB        4
`define UPA_ADDR_W          5
`define UPA_GROUP_EN_W      4
`define UPA_RST_ADDR        5'h00
`define UPA_RST_EN8         8'h00
`define UPA_RST_EN4         4'h0
`define UPA_HTRANS_NONSEQ   2'h2
`define UPA_HTRANS_SEQ      2'h3
`define UPA_HRESP_OKAY      1'b0
`define UPA_IDX_W           12
`define UPA_IDX_LSB         2
`define UPA_IDX_MSB         13
`define UPA_DATA_W          32
`define UPA_RST_WORD        32'h0000_0000
`define UPA_RST_IDX         12'h000
`endif

/* verilog/upa_phy_addr_bank.v */
// utopia input phy address and enable registers behind an ahb-lite slave
// assumes one clock, single-word transfers, the utopia input clock running
//
// Contract
// [R1] eight link registers hold a 5-bit input phy address in bits 4:0 each.
// [R2] bits 7:5 of every address register read as zero whatever was written.
// [R3] four group registers hold a 5-bit input phy address in bits 4:0 each.
// [R4] the link enable register bit n activates link n's address when set.
// [R5] software touches these registers only while the utopia input clock runs.
// [R6] the group enable register low four bits activate groups 0 to 3, upper bits reserved.
// [R7] after reset every address field and enable bit reads zero.
`timescale 1ns/100ps
`include "upa_defs.vh"

module upa_phy_addr_bank
#(
  parameter NUM_LINKS  = 8,
  parameter NUM_GROUPS = 4
)
(
  input  wire                            clk,
  input  wire                            rst_b,
  input  wire                            hsel,
  input  wire [31:0]                     haddr,
  input  wire [1:0]                      htrans,
  input  wire                            hwrite,
  input  wire [2:0]                      hsize,
  input  wire [31:0]                     hwdata,
  input  wire                            hready,
  output wire                            hreadyout,
  output wire                            hresp,
  output reg  [31:0]                     hrdata,
  output wire [NUM_LINKS*5-1:0]          link_phy_addr,
  output wire [NUM_LINKS-1:0]            link_phy_active,
  output wire [NUM_GROUPS*5-1:0]         group_phy_addr,
  output wire [NUM_GROUPS-1:0]           group_phy_active
);

  // widths taken from the shared constants
  localparam ADDR_W = `UPA_ADDR_W;
  localparam IDX_W  = `UPA_IDX_W;
  localparam DATA_W = `UPA_DATA_W;
  localparam PAD_W  = `UPA_DATA_W - `UPA_ADDR_W;
  localparam LPAD_W = `UPA_DATA_W - NUM_LINKS;
  localparam GPAD_W = `UPA_DATA_W - NUM_GROUPS;
  localparam XPAD_W = `UPA_DATA_W - `UPA_IDX_W;

  // enable registers
  reg  [NUM_LINKS-1:0]         link_en_q;
  reg  [NUM_LINKS-1:0]         link_en_d;
  reg  [NUM_GROUPS-1:0]        group_en_q;
  reg  [NUM_GROUPS-1:0]        group_en_d;

  // write data phase tracking
  reg                          wr_pend_q;
  reg                          wr_pend_d;
  reg  [IDX_W-1:0]             wr_idx_q;
  reg  [IDX_W-1:0]             wr_idx_d;

  // read data path
  reg  [DATA_W-1:0]            rdata_d;
  reg  [DATA_W-1:0]            hrdata_d;

  // address phase decode
  wire                         active_htrans;
  wire                         take;
  wire                         take_wr;
  wire                         take_rd;
  wire [IDX_W-1:0]             a_idx;
  wire [DATA_W-1:0]            a_idx_ext;
  wire [DATA_W-1:0]            wr_idx_ext;

  // per-entry hits and stored values
  wire [NUM_LINKS-1:0]         link_wr_hit;
  wire [NUM_LINKS-1:0]         link_rd_hit;
  wire [NUM_GROUPS-1:0]        group_wr_hit;
  wire [NUM_GROUPS-1:0]        group_rd_hit;
  wire                         link_en_wr_hit;
  wire                         link_en_rd_hit;
  wire                         group_en_wr_hit;
  wire                         group_en_rd_hit;
  wire [NUM_LINKS*ADDR_W-1:0]  link_addr_flat;
  wire [NUM_GROUPS*ADDR_W-1:0] group_addr_flat;
  integer                      i;
  genvar                       g;

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = `UPA_HRESP_OKAY;

  // a transfer is taken on nonseq or seq with the bus ready
  assign active_htrans = (htrans == `UPA_HTRANS_NONSEQ) || (htrans == `UPA_HTRANS_SEQ);
  assign take          = hsel && hready && active_htrans;
  assign take_wr       = take && hwrite;
  assign take_rd       = take && !hwrite;
  assign a_idx         = haddr[`UPA_IDX_MSB:`UPA_IDX_LSB];
  assign a_idx_ext     = {{XPAD_W{1'b0}}, a_idx};
  assign wr_idx_ext    = {{XPAD_W{1'b0}}, wr_idx_q};

  // enable register decode
  assign link_en_wr_hit  = wr_pend_q && (wr_idx_q == `UPA_IDX_LINK_EN);
  assign group_en_wr_hit = wr_pend_q && (wr_idx_q == `UPA_IDX_GROUP_EN);
  assign link_en_rd_hit  = (a_idx == `UPA_IDX_LINK_EN);
  assign group_en_rd_hit = (a_idx == `UPA_IDX_GROUP_EN);

  // remember a taken write until its data phase
  always @*
  begin
    wr_pend_d = take_wr;
    if (take)
    begin
      wr_idx_d = a_idx;
    end
    else
    begin
      wr_idx_d = wr_idx_q;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= `UPA_RST_IDX;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q  <= wr_idx_d;
    end
  end

  // one address register per link
  generate
    for (g = 0; g < NUM_LINKS; g = g + 1)
    begin : g_link
      localparam integer LINK_IDX = `UPA_IDX_LINK_ADDR0 + g;
      reg [ADDR_W-1:0] addr_q;
      reg [ADDR_W-1:0] addr_d;

      assign link_wr_hit[g] = wr_pend_q && (wr_idx_ext == LINK_IDX);
      assign link_rd_hit[g] = (a_idx_ext == LINK_IDX);

      always @*
      begin
        if (link_wr_hit[g])
        begin
          addr_d = hwdata[`UPA_ADDR_MSB:0]; // [R1]
        end
        else
        begin
          addr_d = addr_q;
        end
      end

      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          addr_q <= `UPA_RST_ADDR; // [R7]
        end
        else
        begin
          addr_q <= addr_d;
        end
      end

      assign link_addr_flat[g*ADDR_W +: ADDR_W] = addr_q;
      assign link_phy_addr[g*ADDR_W +: ADDR_W]  = addr_q; // [R1]
      assign link_phy_active[g]                 = link_en_q[g]; // [R4]
    end
  endgenerate

  // one address register per group
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1)
    begin : g_group
      localparam integer GROUP_IDX = `UPA_IDX_GROUP_ADDR0 + g;
      reg [ADDR_W-1:0] addr_q;
      reg [ADDR_W-1:0] addr_d;

      assign group_wr_hit[g] = wr_pend_q && (wr_idx_ext == GROUP_IDX);
      assign group_rd_hit[g] = (a_idx_ext == GROUP_IDX);

      always @*
      begin
        if (group_wr_hit[g])
        begin
          addr_d = hwdata[`UPA_ADDR_MSB:0]; // [R3]
        end
        else
        begin
          addr_d = addr_q;
        end
      end

      always @(posedge clk)
      begin
        if (!rst_b)
        begin
          addr_q <= `UPA_RST_ADDR; // [R7]
        end
        else
        begin
          addr_q <= addr_d;
        end
      end

      assign group_addr_flat[g*ADDR_W +: ADDR_W] = addr_q;
      assign group_phy_addr[g*ADDR_W +: ADDR_W]  = addr_q; // [R3]
      assign group_phy_active[g]                 = group_en_q[g]; // [R6]
    end
  endgenerate

  // link enable register
  always @*
  begin
    if (link_en_wr_hit)
    begin
      link_en_d = hwdata[NUM_LINKS-1:0]; // [R4]
    end
    else
    begin
      link_en_d = link_en_q;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      link_en_q <= {NUM_LINKS{1'b0}}; // [R7]
    end
    else
    begin
      link_en_q <= link_en_d;
    end
  end

  // group enable register, reserved upper bits not stored
  always @*
  begin
    if (group_en_wr_hit)
    begin
      group_en_d = hwdata[NUM_GROUPS-1:0]; // [R6]
    end
    else
    begin
      group_en_d = group_en_q;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      group_en_q <= {NUM_GROUPS{1'b0}}; // [R7]
    end
    else
    begin
      group_en_q <= group_en_d;
    end
  end

  // read mux, selected in the address phase
  always @*
  begin
    rdata_d = `UPA_RST_WORD;
    for (i = 0; i < NUM_LINKS; i = i + 1)
    begin
      if (link_rd_hit[i])
        rdata_d = {{PAD_W{1'b0}}, link_addr_flat[i*ADDR_W +: ADDR_W]}; // [R2]
    end
    for (i = 0; i < NUM_GROUPS; i = i + 1)
    begin
      if (group_rd_hit[i])
        rdata_d = {{PAD_W{1'b0}}, group_addr_flat[i*ADDR_W +: ADDR_W]}; // [R2]
    end
    if (link_en_rd_hit)
    begin
      rdata_d = {{LPAD_W{1'b0}}, link_en_q}; // [R4]
    end
    if (group_en_rd_hit)
    begin
      rdata_d = {{GPAD_W{1'b0}}, group_en_q}; // [R6]
    end
  end

  // read data register, loaded when a read is taken
  always @*
  begin
    if (take_rd)
    begin
      hrdata_d = rdata_d;
    end
    else
    begin
      hrdata_d = hrdata;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      hrdata <= `UPA_RST_WORD; // [R7]
    end
    else
    begin
      hrdata <= hrdata_d;
    end
  end

endmodule // upa_phy_addr_bank

/* dv/upa_monitor.sv */
// port assertions for the bank; bound below
// assumes the bank ports on one clock, default widths
`timescale 1ns/100ps
module upa_mon
(
  input wire        clk,
  input wire        rst_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire [39:0] link_phy_addr,
  input wire [7:0]  link_phy_active,
  input wire [19:0] group_phy_addr,
  input wire [3:0]  group_phy_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bad reply");
  a_rd_upper: assert property (hrdata[31:8] == 24'h000000) else $error("upper bits set");
  a_rd_addr_hi: assert property (hsel && hready && htrans[1] && !hwrite && (haddr[13:2] < 12'h00C)
    |=> hrdata[31:5] == 27'h0000000) else $error("address read upper bits set");
  a_rst_clear: assert property (!$past(rst_b) |-> link_phy_active == 8'h00) else $error("not cleared");
  a_rst_addr: assert property (!$past(rst_b) |-> (link_phy_addr == 40'h0) && (group_phy_addr == 20'h0)
    && (group_phy_active == 4'h0)) else $error("addresses not cleared");
  a_link_en_wr: assert property ($changed(link_phy_active) |-> $past(hsel, 2) && $past(hwrite, 2)
    && (($past(haddr, 2) & 32'h00003FFC) == 32'h00000030)) else $error("link enable changed without write");
  a_grp_en_wr: assert property ($changed(group_phy_active) |-> $past(hsel, 2) && $past(hwrite, 2)
    && (($past(haddr, 2) & 32'h00003FFC) == 32'h00000034)) else $error("group enable changed without write");
endmodule // upa_mon
bind upa_phy_addr_bank upa_mon u_mon(.*);

/* dv/upa_atm.sv */
// atm-layer poller: flags a polled phy address that is answered
`timescale 1ns/100ps
module upa_atm(input wire [39:0] la,input wire [7:0] le,input wire [19:0] ga,input wire [3:0] ge,
input wire [4:0] poll,output reg hit);
integer i;
always @*
begin
hit=0;
for(i=0;i<8;i=i+1)if(le[i]&&la[5*i+:5]==poll)hit=1;
for(i=0;i<4;i=i+1)if(ge[i]&&ga[5*i+:5]==poll)hit=1;
end
endmodule // upa_atm

/* dv/tb_top.sv */
// ahb-lite bench for the bank; polls through the atm model
`timescale 1ns/100ps
module tb_top;
reg clk=0,rst_b=0,hsel=0,hw=0;reg [1:0] ht=0;reg [31:0] ha=0,wd=0,q;reg [4:0] poll=0;reg [95:0] r[0:6];
wire hr,hresp,hit;wire [31:0] rd;wire [39:0] la;wire [7:0] le;wire [19:0] ga;wire [3:0] ge;
integer mismatches=0,n_checks=0,i;
always #2.5 clk=~clk;
upa_phy_addr_bank DUT(.clk(clk),.rst_b(rst_b),.hsel(hsel),.haddr(ha),.htrans(ht),.hwrite(hw),.hsize(3'h2),
.hwdata(wd),.hready(hr),.hreadyout(hr),.hresp(hresp),.hrdata(rd),.link_phy_addr(la),.link_phy_active(le),
.group_phy_addr(ga),.group_phy_active(ge));
upa_atm u_atm(.la(la),.le(le),.ga(ga),.ge(ge),.poll(poll),.hit(hit));
task chk(input [23:0] n,input [31:0] s,e);
begin
n_checks=n_checks+1;
if(s!==e)
begin
mismatches=mismatches+1;$display("[ERR] %s exp %h seen %h",n,e,s);
end
end
endtask
task xf(input w,input [31:0] a,d);
begin
hsel<=1;ha<=a;ht<=2'h2;hw<=w;@(posedge clk);while(!hr)@(posedge clk);
hsel<=0;ht<=2'h0;wd<=d;@(posedge clk);while(!hr)@(posedge clk);q=rd;
end
endtask
task end_sim;
begin
$display("checks %0d mismatches %0d",n_checks,mismatches);
if(mismatches==0&&n_checks>0)$display("RESULT: PASS");
else $display("RESULT: FAIL");
$finish;
end
endtask
initial begin #20000;mismatches=mismatches+1;end_sim;end
initial
begin
r[0]={32'h0,32'hFF,32'h1F};r[1]={32'h1C,32'hA5,32'h5};r[2]={32'h20,32'h3E,32'h1E};r[3]={32'h2C,32'h1,32'h1};
r[4]={32'h30,32'h81,32'h81};r[5]={32'h34,32'hFF,32'hF};r[6]={32'h38,32'hFF,32'h0};
repeat(20)@(posedge clk);rst_b<=1;@(posedge clk);
xf(0,32'h30,0);chk("rst",q,0);
for(i=0;i<7;i=i+1)xf(1,r[i][95:64],r[i][63:32]);
for(i=0;i<7;i=i+1)begin xf(0,r[i][95:64],0);chk("reg",q,r[i][31:0]);end
chk("act",{ge,le},32'hF81);
chk("adr",{ga[19:15],ga[4:0],la[39:35],la[4:0]},32'h0F8BF);
xf(1,32'h30,32'h80);poll<=5'h1F;@(posedge clk);@(posedge clk);chk("hit",hit,0);
poll<=5'h05;@(posedge clk);@(posedge clk);chk("hit",hit,1);
hsel<=1;ha<=32'h34;ht<=2'h3;hw<=0;@(posedge clk);while(!hr)@(posedge clk);
hsel<=0;ht<=2'h0;@(posedge clk);while(!hr)@(posedge clk);chk("seq",rd,32'hF);
$display("registers done");
rst_b<=0;repeat(2)@(posedge clk);rst_b<=1;@(posedge clk);chk("clr",|{ga,la,ge,le},0);
$display("reset done");
end_sim;
end
endmodule // tb_top
